// >>> sdram_cmd_cfg.svh
// Constants of the SDRAM command interface: geometry, field positions, timing.
// Assumes a 100 MHz device clock; included by the package and the top module.
`ifndef SDRAM_CMD_CFG_SVH
`define SDRAM_CMD_CFG_SVH
`define BANK_COUNT     4
`define BANK_W         2
`define ROW_W          13
`define ROW_COUNT      8192
`define COL_W          10
`define DQ_W           8
`define MODE_W         14
`define MODE_OP_MSB    11
`define AP_BIT         10
`define BURST_LEN      3'h4
`define BEAT_W         3
`define CLK_PERIOD_PS  10000
`define WR_AP_DELAY_PS 7500
// One clock after the last data, then the delay rounded up to whole cycles
`define WR_AP_CYC      (1 + ((`WR_AP_DELAY_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS))
`endif

// >>> sdram_cmd_pkg.sv
// Types of the SDRAM command interface.
// Assumes sdram_cmd_cfg.svh is on the include path.
`include "sdram_cmd_cfg.svh"
package sdram_cmd_pkg;
  typedef logic [`BANK_W-1:0] bank_t;
  typedef logic [`ROW_W-1:0]  row_t;
  typedef logic [`COL_W-1:0]  col_t;
  typedef logic [`DQ_W-1:0]   data_t;
  // Command codes equal the {ras_n, cas_n, we_n} strobe pattern
  typedef enum logic [2:0] {
    CMD_MODE_LOAD = 3'b000,
    CMD_REFRESH   = 3'b001,
    CMD_PRECHARGE = 3'b010,
    CMD_ACTIVE    = 3'b011,
    CMD_WRITE     = 3'b100,
    CMD_READ      = 3'b101,
    CMD_BURST_END = 3'b110,
    CMD_NOP       = 3'b111
  } cmd_t;
  // Burst engine states
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10
  } op_t;
endpackage

// >>> sdram_command_interface.sv
// Command interface of a four-bank SDR DRAM, x8 organisation.
// Assumes an external memory controller drives all inputs synchronous to
// clk_sys_i and a storage array outside answers reads in the same cycle.
// Limitation: burst length four, read latency two and the x8 column width are
// fixed; the mode register is stored for the controller but not interpreted.
// Illegal sequences (access to a closed bank, early commands) are not policed.
`timescale 1ns/1ns
`include "sdram_cmd_cfg.svh"
module sdram_command_interface (
  input  wire logic                 clk_sys_i,          // Device clock
  input  wire logic                 rstn_i,             // Async reset, low
  input  wire logic                 cs_n_i,             // Chip select, low
  input  wire logic                 ras_n_i,            // Row strobe, low
  input  wire logic                 cas_n_i,            // Column strobe, low
  input  wire logic                 we_n_i,             // Write strobe, low
  input  wire logic                 clk_gate_i,         // Clock gate, high on
  input  wire logic                 bank_select_low_i,  // Bank select bit 0
  input  wire logic                 bank_select_high_i, // Bank select bit 1
  input  wire sdram_cmd_pkg::row_t  addr_i,             // Address lines
  input  wire logic                 dqm_i,              // Data mask
  input  wire sdram_cmd_pkg::data_t dq_i,               // Data pin input
  output logic                      dq_oe_o,            // Data pin enable
  output sdram_cmd_pkg::data_t      dq_o,               // Data pin output
  input  wire sdram_cmd_pkg::data_t array_rdata_i,      // Array read data
  output logic                      array_rd_o,         // Array read strobe
  output logic                      array_we_o,         // Array write strobe
  output sdram_cmd_pkg::bank_t      array_bank_o,       // Array bank
  output sdram_cmd_pkg::row_t       array_row_o,        // Array row
  output sdram_cmd_pkg::col_t       array_col_o,        // Array column
  output sdram_cmd_pkg::data_t      array_wdata_o,      // Array write data
  output logic                      refresh_strobe_o,   // Row refresh pulse
  output sdram_cmd_pkg::row_t       refresh_row_o,      // Row being refreshed
  output logic                      self_refresh_o,     // In self refresh
  output logic [`BANK_COUNT-1:0]    bank_open_o,        // Bank has open row
  output logic [`BANK_COUNT*`ROW_W-1:0] open_row_o,     // Open row per bank
  output logic [`MODE_W-1:0]        mode_reg_o          // Mode register
);
  import sdram_cmd_pkg::*;

  // Strobe decode; deselect reads as NOP so nothing is registered
  function automatic cmd_t decode(input logic cs_n, input logic [2:0] strb);
    decode = cs_n ? CMD_NOP : cmd_t'(strb);
  endfunction

  // One-hot bank mask, used for open, close and truncate decisions
  function automatic logic [`BANK_COUNT-1:0] bank_hot(input bank_t b);
    bank_hot = {{(`BANK_COUNT-1){1'b0}}, 1'b1} << b;
  endfunction

  // Burst engine state
  op_t                   op_q, op_d;           // Running burst kind
  logic [`BEAT_W-1:0]    beats_q, beats_d;     // Beats still to issue
  bank_t                 bank_q, bank_d;       // Bank of running burst
  col_t                  col_q, col_d;         // Next beat column
  logic                  ap_q, ap_d;           // Auto precharge at end
  // Write recovery before auto precharge, independent of new bursts
  logic [`BEAT_W-1:0]    rec_q, rec_d;         // Recovery cycles left
  bank_t                 rec_bank_q, rec_bank_d; // Bank to close
  // Bank tracking
  logic [`BANK_COUNT-1:0]        bank_open_q;  // Open flags
  logic [`BANK_COUNT*`ROW_W-1:0] row_q;        // Open rows, flat
  logic [`MODE_W-1:0]            mode_q;       // Mode register
  // Refresh and power state
  row_t                  ref_row_q;            // Internal refresh counter
  logic                  ref_strb_q;           // Refresh pulse
  logic                  sref_q;               // Self refresh active
  // Array and pin side
  logic                  rd_q;                 // Read beat issued
  logic                  we_q;                 // Unmasked write beat
  bank_t                 abank_q;              // Beat bank
  row_t                  arow_q;               // Beat row
  col_t                  acol_q;               // Beat column
  data_t                 wdata_q;              // Beat write data
  logic                  dqm_q;                // Mask seen with read beat
  logic                  oe_q;                 // Pin driver enable
  data_t                 dq_q;                 // Pin output data

  // Everything below the decode looks only at values captured at the rising
  // edge, so strobe changes between edges can never start a command.
  // Command decode; inputs count only at the sampling edge
  wire cmd_t  cmd      = decode(cs_n_i, {ras_n_i, cas_n_i, we_n_i});
  wire bank_t bank_sel = {bank_select_high_i, bank_select_low_i};
  wire        ap_bit   = addr_i[`AP_BIT];
  // Commands other than self refresh entry need the clock gate high; self refresh masks all of them
  wire        accept   = clk_gate_i & ~sref_q;
  wire        is_act   = accept && (cmd == CMD_ACTIVE);
  wire        is_pre   = accept && (cmd == CMD_PRECHARGE);
  wire        is_rd    = accept && (cmd == CMD_READ);
  wire        is_wr    = accept && (cmd == CMD_WRITE);
  wire        is_bst   = accept && (cmd == CMD_BURST_END);
  wire        is_mode  = accept && (cmd == CMD_MODE_LOAD);
  wire        is_aref  = accept && (cmd == CMD_REFRESH);
  wire        is_sref  = ~sref_q && ~clk_gate_i && (cmd == CMD_REFRESH);
  // x8 column comes from A9..A0
  wire col_t  cmd_col  = addr_i[`COL_W-1:0];
  // Precharge reach: one bank when bit low, all when bit high
  wire [`BANK_COUNT-1:0] pre_mask = ap_bit ? {`BANK_COUNT{1'b1}} : bank_hot(bank_sel);
  // A precharge that reaches the burst bank truncates the burst
  wire        pre_hits = is_pre && ((pre_mask & bank_hot(bank_q)) != '0);

  // Combined beat and close decisions
  logic                  rd_beat;              // Read beat this edge
  logic                  wr_beat;              // Write beat this edge
  bank_t                 beat_bank;            // Beat bank
  col_t                  beat_col;             // Beat column
  logic [`BANK_COUNT-1:0] close_mask;          // Banks closing now

  // Priority, lowest first: natural burst progress, then terminate or a
  // precharge that reaches the burst bank, then a new READ or WRITE. A new
  // access therefore always wins, which lets the controller chain bursts
  // back to back with no gap cycle.
  // Burst engine next state; a new READ or WRITE overrides the running burst
  always_comb begin
    op_d       = op_q;
    beats_d    = beats_q;
    bank_d     = bank_q;
    col_d      = col_q;
    ap_d       = ap_q;
    rec_d      = rec_q;
    rec_bank_d = rec_bank_q;
    rd_beat    = 1'b0;
    wr_beat    = 1'b0;
    beat_bank  = bank_q;
    beat_col   = col_q;
    close_mask = is_pre ? pre_mask : '0;
    // Write recovery countdown, then close the written row
    if (rec_q != '0) begin
      rec_d = rec_q - 1'b1;
      if (rec_q == 1'b1) begin
        close_mask = close_mask | bank_hot(rec_bank_q);
      end
    end
    case (op_q)
      OP_READ, OP_WRITE: begin
        if (beats_q != '0) begin
          // Continue burst one column per clock
          rd_beat = (op_q == OP_READ);
          wr_beat = (op_q == OP_WRITE);
          beats_d = beats_q - 1'b1;
          col_d   = col_q + 1'b1;
        end else begin
          // Burst done; auto precharge now for reads, after recovery for writes
          op_d = OP_IDLE;
          if (ap_q && (op_q == OP_READ)) begin
            close_mask = close_mask | bank_hot(bank_q);
          end else if (ap_q) begin
            rec_d      = `BEAT_W'(`WR_AP_CYC);
            rec_bank_d = bank_q;
          end
        end
      end
      default: begin
        op_d = OP_IDLE;
      end
    endcase
    // Terminate or precharge cuts the burst; no further beats
    if (is_bst || pre_hits) begin
      op_d    = OP_IDLE;
      beats_d = '0;
      rd_beat = 1'b0;
      wr_beat = 1'b0;
    end
    // New access starts with its first beat in the command cycle
    if (is_rd || is_wr) begin
      op_d      = is_rd ? OP_READ : OP_WRITE;
      bank_d    = bank_sel;
      beats_d   = `BURST_LEN - 1'b1;
      col_d     = cmd_col + 1'b1;
      ap_d      = ap_bit;
      rd_beat   = is_rd;
      wr_beat   = is_wr;
      beat_bank = bank_sel;
      beat_col  = cmd_col;
    end
  end

  // Burst engine registers
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op_q       <= OP_IDLE;
      beats_q    <= '0;
      bank_q     <= '0;
      col_q      <= '0;
      ap_q       <= 1'b0;
      rec_q      <= '0;
      rec_bank_q <= '0;
    end else begin
      op_q       <= op_d;
      beats_q    <= beats_d;
      bank_q     <= bank_d;
      col_q      <= col_d;
      ap_q       <= ap_d;
      rec_q      <= rec_d;
      rec_bank_q <= rec_bank_d;
    end
  end

  // When a close and an ACTIVE reach the same bank on one edge the ACTIVE
  // wins; auto precharge at the end of a read burst and write recovery can close a bank without a command.
  // Per-bank open flag; other banks untouched by a command
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bank_open_q <= '0;
    end else begin
      bank_open_q <= (bank_open_q & ~close_mask) | (is_act ? bank_hot(bank_sel) : '0);
    end
  end

  // Open row capture; row survives until the next ACTIVE to its bank
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      row_q <= '0;
    end else if (is_act) begin
      row_q[bank_sel*`ROW_W +: `ROW_W] <= addr_i;
    end
  end

  // Mode register load; caller keeps banks idle and honours the wait
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= '0;
    end else if (is_mode) begin
      mode_q <= {bank_select_high_i, bank_select_low_i, addr_i[`MODE_OP_MSB:0]};
    end
  end

  // The counter wraps after the last row, so repeated refresh walks every row
  // without help from the controller.
  // Refresh: rows come from the internal counter, address pins unused
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_row_q  <= '0;
      ref_strb_q <= 1'b0;
    end else begin
      ref_strb_q <= is_aref | is_sref;
      if (is_aref || is_sref) begin
        ref_row_q <= ref_row_q + 1'b1;
      end
    end
  end

  // Leaving self refresh needs only one edge with the gate high; the wait the
  // controller keeps after that is not tracked here.
  // Self refresh held while the clock gate stays low
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sref_q <= 1'b0;
    end else if (is_sref) begin
      sref_q <= 1'b1;
    end else if (clk_gate_i) begin
      sref_q <= 1'b0;
    end
  end

  // Array access; write mask applies to the data of the same edge
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_q    <= 1'b0;
      we_q    <= 1'b0;
      abank_q <= '0;
      arow_q  <= '0;
      acol_q  <= '0;
      wdata_q <= '0;
    end else begin
      rd_q    <= rd_beat;
      we_q    <= wr_beat & ~dqm_i;
      abank_q <= beat_bank;
      arow_q  <= row_q[beat_bank*`ROW_W +: `ROW_W];
      acol_q  <= beat_col;
      wdata_q <= dq_i;
    end
  end

  // Read data is registered once more here so the pins never see the
  // combinational path through the storage array.
  // Read pins: mask of the beat edge gates the driver for the next-but-one
  // edge, a two-clock lag as the controller sees it
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dqm_q <= 1'b0;
      oe_q  <= 1'b0;
      dq_q  <= '0;
    end else begin
      dqm_q <= dqm_i;
      oe_q  <= rd_q & ~dqm_q;
      dq_q  <= array_rdata_i;
    end
  end

  // Outputs straight from flip-flops
  assign dq_oe_o          = oe_q;
  assign dq_o             = dq_q;
  assign array_rd_o       = rd_q;
  assign array_we_o       = we_q;
  assign array_bank_o     = abank_q;
  assign array_row_o      = arow_q;
  assign array_col_o      = acol_q;
  assign array_wdata_o    = wdata_q;
  assign refresh_strobe_o = ref_strb_q;
  assign refresh_row_o    = ref_row_q;
  assign self_refresh_o   = sref_q;
  assign bank_open_o      = bank_open_q;
  assign open_row_o       = row_q;
  assign mode_reg_o       = mode_q;
endmodule // sdram_command_interface

// >>> sdram_cmd_properties.sv
// Concurrent checks on the ports of the SDRAM command interface.
// Assumes it is bound to sdram_command_interface; one clock, async low reset.
`timescale 1ns/1ns
module sdram_cmd_checker (
  input wire logic                 clk_sys_i,          // Device clock
  input wire logic                 rstn_i,             // Reset, low
  input wire logic                 cs_n_i,             // Chip select, low
  input wire logic                 ras_n_i,            // Row strobe
  input wire logic                 cas_n_i,            // Column strobe
  input wire logic                 we_n_i,             // Write strobe
  input wire logic                 clk_gate_i,         // Clock gate
  input wire logic                 bank_select_low_i,  // Bank bit 0
  input wire logic                 bank_select_high_i, // Bank bit 1
  input wire sdram_cmd_pkg::row_t  addr_i,             // Address
  input wire logic                 dqm_i,              // Data mask
  input wire sdram_cmd_pkg::data_t dq_i,               // Write data
  input wire logic                 dq_oe_o,            // Data enable
  input wire logic                 array_rd_o,         // Read beat
  input wire logic                 array_we_o,         // Write beat
  input wire sdram_cmd_pkg::data_t array_wdata_o,      // Beat data
  input wire logic                 refresh_strobe_o,   // Refresh pulse
  input wire sdram_cmd_pkg::row_t  refresh_row_o,      // Refresh row
  input wire logic                 self_refresh_o,     // Self refresh
  input wire logic [3:0]           bank_open_o,        // Open banks
  input wire logic [51:0]          open_row_o,         // Open rows
  input wire logic [13:0]          mode_reg_o          // Mode register
);
  import sdram_cmd_pkg::*;
  logic [2:0] cmd;  // Strobe pattern
  logic [1:0] bk;   // Selected bank
  logic       take; // A command is accepted at this edge
  assign cmd  = {ras_n_i, cas_n_i, we_n_i};
  assign bk   = {bank_select_high_i, bank_select_low_i};
  assign take = !cs_n_i && clk_gate_i && !self_refresh_o;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // An accepted ACTIVE must open its bank with the sampled row
  act_opens_row_a: assert property (take && cmd == CMD_ACTIVE |=> bank_open_o[$past(bk)] && open_row_o[$past(bk)*13 +: 13] == $past(addr_i)) else $error("row not opened");
  pre_all_a: assert property (take && cmd == CMD_PRECHARGE && addr_i[10] |=> bank_open_o == 4'h0) else $error("banks not all closed");
  pre_one_a: assert property (take && cmd == CMD_PRECHARGE && !addr_i[10] |=> !bank_open_o[$past(bk)]) else $error("bank not closed");
  inhibit_idle_a: assert property (cs_n_i |=> $stable(mode_reg_o) && !refresh_strobe_o && (bank_open_o & ~$past(bank_open_o)) == 4'h0) else $error("inhibit acted");
  nop_idle_a: assert property (take && cmd == CMD_NOP |=> $stable(mode_reg_o) && !refresh_strobe_o && (bank_open_o & ~$past(bank_open_o)) == 4'h0) else $error("nop acted");
  mode_load_a: assert property (take && cmd == CMD_MODE_LOAD |=> mode_reg_o == $past({bk, addr_i[11:0]})) else $error("mode load wrong");
  auto_refresh_a: assert property (take && cmd == CMD_REFRESH |=> refresh_strobe_o && refresh_row_o == $past(refresh_row_o) + 13'h1) else $error("refresh wrong");
  self_entry_a: assert property (!cs_n_i && !clk_gate_i && !self_refresh_o && cmd == CMD_REFRESH |=> self_refresh_o && refresh_strobe_o) else $error("no self refresh");
  read_mask_a: assert property (array_rd_o |=> dq_oe_o == !$past(dqm_i, 2)) else $error("read mask lag wrong");
  read_float_a: assert property (!array_rd_o |=> !dq_oe_o) else $error("drive without beat");
  write_mask_a: assert property (array_we_o |-> !$past(dqm_i) && array_wdata_o == $past(dq_i)) else $error("masked write stored");
  act_c: cover property (take && cmd == CMD_ACTIVE);
  self_c: cover property ($rose(self_refresh_o));
  rd_c: cover property (dq_oe_o);
  wr_c: cover property (array_we_o);
endmodule // sdram_cmd_checker
bind sdram_command_interface sdram_cmd_checker sdram_cmd_checker_i (.clk_sys_i, .rstn_i, .cs_n_i, .ras_n_i,
  .cas_n_i, .we_n_i, .clk_gate_i, .bank_select_low_i, .bank_select_high_i, .addr_i, .dqm_i, .dq_i, .dq_oe_o,
  .array_rd_o, .array_we_o, .array_wdata_o, .refresh_strobe_o, .refresh_row_o, .self_refresh_o, .bank_open_o,
  .open_row_o, .mode_reg_o);

// >>> sdram_array_model.sv
// Behavioural storage array behind the command interface, 256 locations by column.
// Assumes read data is wanted in the same cycle as the strobe and address.
`timescale 1ns/1ns
module sdram_array_model (
  input  wire logic                 clk_sys_i, // Device clock
  input  wire logic                 rd_i,      // Read strobe
  input  wire logic                 we_i,      // Write strobe
  input  wire sdram_cmd_pkg::col_t  col_i,     // Column
  input  wire sdram_cmd_pkg::data_t wdata_i,   // Write data
  output sdram_cmd_pkg::data_t      rdata_o    // Read data
);
  import sdram_cmd_pkg::*;
  data_t mem [256];    // Small store, low column bits only
  data_t last_q = '0;  // Last value handed out
  initial for (int i = 0; i < 256; i++) mem[i] = data_t'(i) ^ 8'h5a;
  // Store only strobed beats; masked lanes never reach here
  always @(posedge clk_sys_i) if (we_i) mem[col_i[7:0]] <= wdata_i;
  always @(posedge clk_sys_i) if (rd_i) last_q <= rdata_o;
  // Outside reads show the inverse so a stale sample cannot pass
  assign rdata_o = rd_i ? mem[col_i[7:0]] : ~last_q;
endmodule // sdram_array_model

// >>> sdram_command_interface_tb.sv
// Self-checking bench: drives controller commands and checks the port results.
// Assumes sdram_cmd_pkg, the array model and the checker are compiled first.
`timescale 1ns/1ns
module sdram_command_interface_tb;
  import sdram_cmd_pkg::*;
  logic clk_sys_i = 0, rstn_i = 0, cs_n_i = 1, ras_n_i = 1, cas_n_i = 1, we_n_i = 1;
  logic clk_gate_i = 1, bank_select_low_i = 0, bank_select_high_i = 0, dqm_i = 0;
  row_t addr_i = '0;  // Address lines
  data_t dq_i = '0;   // Write data
  wire data_t dq_o, array_rdata_i, array_wdata_o;
  wire bank_t array_bank_o;
  wire row_t array_row_o, refresh_row_o;
  wire col_t array_col_o;
  wire logic dq_oe_o, array_rd_o, array_we_o, refresh_strobe_o, self_refresh_o;
  wire logic [3:0] bank_open_o;
  wire logic [51:0] open_row_o;
  wire logic [13:0] mode_reg_o;
  int failures = 0, num_checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  sdram_command_interface sdram_command_interface_i (.clk_sys_i, .rstn_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i,
    .clk_gate_i, .bank_select_low_i, .bank_select_high_i, .addr_i, .dqm_i, .dq_i, .dq_oe_o, .dq_o, .array_rdata_i,
    .array_rd_o, .array_we_o, .array_bank_o, .array_row_o, .array_col_o, .array_wdata_o, .refresh_strobe_o,
    .refresh_row_o, .self_refresh_o, .bank_open_o, .open_row_o, .mode_reg_o);
  sdram_array_model sdram_array_model_i (.clk_sys_i, .rd_i(array_rd_o), .we_i(array_we_o), .col_i(array_col_o),
    .wdata_i(array_wdata_o), .rdata_o(array_rdata_i));
  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string n, logic [51:0] e, logic [51:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Waits whole cycles with NOP on the strobes, ending 1 ns after an edge
  task automatic idle(int n);
    {ras_n_i, cas_n_i, we_n_i} = CMD_NOP;
    repeat (n) begin
      @(posedge clk_sys_i);
      #1;
    end
  endtask
  // One command for one edge; it stands until the next call or idle, so two
  // calls in a row never drive the strobes twice in one time step
  task automatic issue(cmd_t c, bank_t b, row_t a, logic m, data_t d);
    cs_n_i = 0;
    {ras_n_i, cas_n_i, we_n_i} = c;
    {bank_select_high_i, bank_select_low_i} = b;
    addr_i = a;
    dqm_i = m;
    dq_i = d;
    @(posedge clk_sys_i);
    #1;
  endtask
  // Four-beat read with a mask per edge; the row must be open
  task automatic rd(bank_t b, col_t c, logic ap, logic [6:0] m);
    issue(CMD_READ, b, {2'b00, ap, c}, m[0], 8'h00);
    for (int k = 0; k < 6; k++) begin
      chk("array_rd", k < 4, array_rd_o);
      if (k < 4) chk("array_col", col_t'(c + k), array_col_o);
      if (k < 4) chk("array_bank", b, array_bank_o);
      if (k > 0) chk("dq_oe", !m[k-1] && k < 5, dq_oe_o);
      if (k > 0 && k < 5 && !m[k-1]) chk("dq", data_t'(c + k - 1) ^ 8'h5a, dq_o);
      dqm_i = m[k+1];
      idle(1);
    end
    chk("bank_open", !ap, bank_open_o[b]);
  endtask
  initial begin
    idle(12);
    rstn_i = 1;
    chk("bank_open", 4'h0, bank_open_o);
    chk("mode_reg", 14'h0, mode_reg_o);
    idle(10000);
    for (int i = 1; i <= 2; i++) begin
      issue(CMD_REFRESH, 2'h3, 13'h1fff, 1'b1, 8'hff);
      chk("refresh_strobe", 1, refresh_strobe_o);
      chk("refresh_row", i, refresh_row_o);
    end
    chk("bank_open", 4'h0, bank_open_o);
    issue(CMD_MODE_LOAD, 2'h1, 13'h1a5c, 1'b0, 8'h00);
    chk("mode_reg", 14'h1a5c, mode_reg_o);
    idle(2);
    issue(CMD_ACTIVE, 2'h2, 13'h1abc, 1'b0, 8'h00);
    chk("bank_open", 4'h4, bank_open_o);
    chk("open_row2", 13'h1abc, open_row_o[38:26]);
    issue(CMD_ACTIVE, 2'h0, 13'h0123, 1'b0, 8'h00);
    chk("bank_open", 4'h5, bank_open_o);
    chk("open_row0", 13'h0123, open_row_o[12:0]);
    chk("open_row2", 13'h1abc, open_row_o[38:26]);
    cs_n_i = 1;
    {ras_n_i, cas_n_i, we_n_i} = CMD_ACTIVE;
    bank_select_low_i = 1;
    @(posedge clk_sys_i);
    #1;
    chk("bank_open", 4'h5, bank_open_o);
    clk_gate_i = 0;
    issue(CMD_ACTIVE, 2'h1, 13'h0005, 1'b0, 8'h00);
    clk_gate_i = 1;
    chk("bank_open", 4'h5, bank_open_o);
    issue(CMD_NOP, 2'h1, 13'h0005, 1'b0, 8'h00);
    chk("bank_open", 4'h5, bank_open_o);
    rd(2'h2, 10'h010, 1'b1, 7'b0000100);
    rd(2'h0, 10'h3fe, 1'b0, 7'b0010001);
    issue(CMD_READ, 2'h0, 13'h0020, 1'b0, 8'h00);
    issue(CMD_BURST_END, 2'h0, 13'h0000, 1'b0, 8'h00);
    chk("array_rd", 0, array_rd_o);
    idle(3);
    issue(CMD_WRITE, 2'h0, 13'h0040, 1'b0, 8'h11);
    chk("array_we", 1, array_we_o);
    chk("array_wdata", 8'h11, array_wdata_o);
    chk("array_col", 10'h040, array_col_o);
    chk("array_row", 13'h0123, array_row_o);
    issue(CMD_NOP, 2'h0, 13'h0000, 1'b1, 8'h22);
    chk("array_we", 0, array_we_o);
    dqm_i = 0;
    idle(3);
    issue(CMD_WRITE, 2'h0, 13'h0450, 1'b0, 8'h33);
    idle(5);
    chk("bank_open0", 1, bank_open_o[0]);
    idle(1);
    chk("bank_open0", 0, bank_open_o[0]);
    issue(CMD_ACTIVE, 2'h1, 13'h0005, 1'b0, 8'h00);
    issue(CMD_ACTIVE, 2'h3, 13'h0007, 1'b0, 8'h00);
    issue(CMD_PRECHARGE, 2'h1, 13'h0000, 1'b0, 8'h00);
    chk("bank_open", 4'h8, bank_open_o);
    issue(CMD_ACTIVE, 2'h0, 13'h0009, 1'b0, 8'h00);
    issue(CMD_PRECHARGE, 2'h0, 13'h0400, 1'b0, 8'h00);
    chk("bank_open", 4'h0, bank_open_o);
    clk_gate_i = 0;
    issue(CMD_REFRESH, 2'h0, 13'h0000, 1'b0, 8'h00);
    chk("self_refresh", 1, self_refresh_o);
    issue(CMD_ACTIVE, 2'h1, 13'h0003, 1'b0, 8'h00);
    chk("bank_open", 4'h0, bank_open_o);
    clk_gate_i = 1;
    idle(2);
    chk("self_refresh", 0, self_refresh_o);
    summarize();
  end
  // Run takes about 10,060 cycles; cut off well beyond that
  initial begin
    #500000;
    failures++;
    summarize();
  end
endmodule // sdram_command_interface_tb
